/* File: verilog/ssmio_top.sv */
// Mode selection, relay, display and service gating for the scanner
`timescale 1ns/10ps
`include "ssmio_cfg.svh"
module ssmio_top #(
    parameter int unsigned CNT_W = `SSMIO_CNT_W,
    parameter logic [CNT_W-1:0] DB_CYCLES = CNT_W'(`SSMIO_DB_CYCLES)
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] sw_in_i,
    input wire logic tamper_open_i,
    input wire ssmio_pkg::ssmio_fieldcfg_s field_cfg_i,
    input wire logic [8:0] case_hit_i,
    input wire logic expert_mode_i,
    input wire logic nv_capable_i,
    input wire ssmio_pkg::ssmio_expert_s expert_i,
    input wire logic sab_clr_i,
    output ssmio_pkg::ssmio_relay_s relays_o,
    output ssmio_pkg::ssmio_mode_e mode_o,
    output logic night_o,
    output logic [8:0] case_act_o,
    output logic display_on_o,
    output logic service_on_o,
    output logic teach_start_o,
    output logic [3:0] teach_field_o,
    output logic sabotage_o,
    output logic sab_seen_o,
    output logic [7:0] alloc_active_o,
    output logic [7:0] alloc_pend_o,
    output logic alloc_save_o,
    output logic relay_swap_o
);
    import ssmio_pkg::*;

    typedef struct packed {
        ssmio_mode_e mode;
        logic night;
        logic [8:0] case_act;
        ssmio_relay_s rly;
        logic disp;
        logic svc;
        logic teach_start;
        logic [3:0] teach_field;
        logic sab;
        logic sab_seen;
        logic [7:0] alloc_act;
        logic [7:0] alloc_pend;
        logic alloc_save;
        logic swap;
    } ssmio_st_s;

    ssmio_st_s st_r;
    ssmio_st_s st_nxt;

    logic [4:0] db_level;
    logic [4:0] db_valid;
    logic [4:0] raw_vec;
    logic [3:0] fn;
    logic ready;
    logic alarm_now;
    logic fault_ok;

    assign raw_vec = {tamper_open_i, sw_in_i};

    genvar gi;
    generate
        // One debouncer per switching input plus the tamper contact
        for (gi = 0; gi <= `SSMIO_NUM_IN; gi++) begin : g_db
            ssmio_debounce #(
                .CNT_W(CNT_W),
                .DB_CYCLES(DB_CYCLES)
            ) u_db (
                .sys_clk_i(sys_clk_i),
                .arst_n_i(arst_n_i),
                .raw_i(raw_vec[gi]),
                .level_o(db_level[gi]),
                .valid_o(db_valid[gi])
            );
        end
    endgenerate

    assign ready = &db_valid;

    always_comb begin
        for (int f = 0; f < `SSMIO_NUM_IN; f++) begin
            fn[f] = db_level[st_r.alloc_act[`SSMIO_ALLOC_W*f +: `SSMIO_ALLOC_W]];
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.teach_start = 1'b0;
        st_nxt.alloc_save = 1'b0;
        if (!ready) begin
            st_nxt.mode = SSMIO_ST_WAIT;
        end else if (fn[`SSMIO_FN_TEST]) begin
            st_nxt.mode = SSMIO_ST_TEST;
        end else if (fn[`SSMIO_FN_TEACH]) begin
            st_nxt.mode = SSMIO_ST_TEACH;
        end else if (fn[`SSMIO_FN_ARM]) begin
            st_nxt.mode = SSMIO_ST_DISARMED;
        end else begin
            st_nxt.mode = SSMIO_ST_ARMED;
        end
        st_nxt.night = ready & fn[`SSMIO_FN_NIGHT];
        // several cases may be active together
        if (!ready) begin
            st_nxt.case_act = '0;
        end else if (fn[`SSMIO_FN_NIGHT]) begin
            st_nxt.case_act = field_cfg_i.night_en;
        end else begin
            st_nxt.case_act = field_cfg_i.day_en;
        end
        // latch the configured field on entry
        if (st_nxt.mode == SSMIO_ST_TEACH && st_r.mode != SSMIO_ST_TEACH &&
            field_cfg_i.teach_field < 4'(`SSMIO_NUM_FIELDS)) begin
            st_nxt.teach_start = 1'b1;
            st_nxt.teach_field = field_cfg_i.teach_field;
        end
        if (expert_i.wr && expert_mode_i) begin
            st_nxt.alloc_pend = expert_i.alloc_map;
            if (nv_capable_i) begin
                st_nxt.alloc_act = expert_i.alloc_map;
                st_nxt.alloc_save = 1'b1;
            end
        end
        if (expert_i.wr && expert_mode_i) begin
            st_nxt.swap = expert_i.relay_swap;
        end
        st_nxt.sab = db_valid[`SSMIO_TAMPER_IDX] & db_level[`SSMIO_TAMPER_IDX];
        if (sab_clr_i) begin
            st_nxt.sab_seen = 1'b0;
        end
        // Set beats clear so no tamper event is lost
        if (st_nxt.sab) begin
            st_nxt.sab_seen = 1'b1;
        end
        // armed gates display and service port
        case (st_r.mode)
            SSMIO_ST_ARMED: begin
                st_nxt.disp = 1'b0;
                st_nxt.svc = 1'b0;
            end
            SSMIO_ST_DISARMED,
            SSMIO_ST_TEST,
            SSMIO_ST_TEACH: begin
                st_nxt.disp = 1'b1;
                st_nxt.svc = 1'b1;
            end
            default: begin
                st_nxt.disp = 1'b0;
                st_nxt.svc = 1'b0;
            end
        endcase
        // a hit on any active case raises the alarm in armed and test mode
        // Relays energised means quiet and healthy; failure drops them
        st_nxt.rly.alarm_rly = (st_r.mode != SSMIO_ST_WAIT) &
            ~((st_r.swap) ? ~fault_ok : alarm_now);
        st_nxt.rly.fault_rly = (st_r.mode != SSMIO_ST_WAIT) &
            ((st_r.swap) ? ~alarm_now : fault_ok);
        st_nxt.rly.sab_rly = (st_r.mode != SSMIO_ST_WAIT) & ~st_r.sab;
    end

    assign alarm_now = ((st_r.mode == SSMIO_ST_ARMED) || (st_r.mode == SSMIO_ST_TEST)) &&
        (|(st_r.case_act & case_hit_i));
    // fault shows not armed in test
    assign fault_ok = (st_r.mode == SSMIO_ST_ARMED) || (st_r.mode == SSMIO_ST_DISARMED);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
            st_r.mode <= SSMIO_ST_WAIT;
            st_r.alloc_act <= 8'(`SSMIO_ALLOC_RST);
            st_r.alloc_pend <= 8'(`SSMIO_ALLOC_RST);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign relays_o = st_r.rly;
    assign mode_o = st_r.mode;
    assign night_o = st_r.night;
    assign case_act_o = st_r.case_act;
    assign display_on_o = st_r.disp;
    assign service_on_o = st_r.svc;
    assign teach_start_o = st_r.teach_start;
    assign teach_field_o = st_r.teach_field;
    assign sabotage_o = st_r.sab;
    assign sab_seen_o = st_r.sab_seen;
    assign alloc_active_o = st_r.alloc_act;
    assign alloc_pend_o = st_r.alloc_pend;
    assign alloc_save_o = st_r.alloc_save;
    assign relay_swap_o = st_r.swap;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    chk_wait_relays: assert property (
        !ready |=> (relays_o == '0) && (mode_o == SSMIO_ST_WAIT))
        else $error("relay energised before ready");
    chk_arm_level: assert property (
        ready && !fn[`SSMIO_FN_TEST] && !fn[`SSMIO_FN_TEACH] && !fn[`SSMIO_FN_ARM] |=>
        mode_o == SSMIO_ST_ARMED)
        else $error("low arm input did not arm");
    chk_test_prio: assert property (
        ready && fn[`SSMIO_FN_TEST] |=> mode_o == SSMIO_ST_TEST)
        else $error("test input ignored");
    chk_teach_mode: assert property (
        ready && !fn[`SSMIO_FN_TEST] && fn[`SSMIO_FN_TEACH] |=> mode_o == SSMIO_ST_TEACH)
        else $error("teach input ignored");
    chk_night_cases: assert property (
        ready && fn[`SSMIO_FN_NIGHT] |=>
        night_o && (case_act_o == $past(field_cfg_i.night_en)))
        else $error("night case set wrong");
    chk_armed_quiet: assert property (
        mode_o == SSMIO_ST_ARMED |=> !display_on_o && !service_on_o)
        else $error("display on while armed");
    chk_test_fault: assert property (
        mode_o == SSMIO_ST_TEST && !relay_swap_o |=> !relays_o.fault_rly && display_on_o)
        else $error("test mode fault or display wrong");
    chk_teach_fault: assert property (
        mode_o == SSMIO_ST_TEACH && !relay_swap_o |=> !relays_o.fault_rly && display_on_o)
        else $error("teach mode fault or display wrong");
    chk_alarm_drop: assert property (
        mode_o == SSMIO_ST_ARMED && !relay_swap_o && |(case_act_o & case_hit_i)
        |=> !relays_o.alarm_rly)
        else $error("case hit gave no alarm");
    chk_alloc_guard: assert property (
        !(expert_i.wr && expert_mode_i) |=> $stable(alloc_active_o) && $stable(alloc_pend_o))
        else $error("allocation changed outside expert mode");
    chk_swap_guard: assert property (
        !(expert_i.wr && expert_mode_i) |=> $stable(relay_swap_o))
        else $error("relay swap changed outside expert mode");
    chk_sab_relay: assert property (
        sabotage_o |-> sab_seen_o ##1 !relays_o.sab_rly)
        else $error("sabotage relay not dropped");
    chk_teach_field: assert property (
        teach_start_o |-> mode_o == SSMIO_ST_TEACH && teach_field_o < 4'(`SSMIO_NUM_FIELDS))
        else $error("teach start out of mode");
    chk_disarm_level: assert property (
        ready && !fn[`SSMIO_FN_TEST] && !fn[`SSMIO_FN_TEACH] && fn[`SSMIO_FN_ARM] |=>
        mode_o == SSMIO_ST_DISARMED)
        else $error("high arm input did not disarm");
    chk_day_cases: assert property (
        ready && !fn[`SSMIO_FN_NIGHT] |=>
        !night_o && (case_act_o == $past(field_cfg_i.day_en)))
        else $error("day case set wrong");
    chk_test_alarm: assert property (
        mode_o == SSMIO_ST_TEST && !relay_swap_o && |(case_act_o & case_hit_i)
        |=> !relays_o.alarm_rly)
        else $error("case hit in test gave no alarm");
    chk_teach_pulse: assert property (
        teach_start_o |=> !teach_start_o)
        else $error("teach start longer than one cycle");
    chk_teach_latch: assert property (
        teach_start_o |-> teach_field_o == $past(field_cfg_i.teach_field))
        else $error("teach field not the configured one");
    chk_alloc_nv: assert property (
        expert_i.wr && expert_mode_i && !nv_capable_i |=>
        $stable(alloc_active_o) && !alloc_save_o)
        else $error("allocation activated without storage");
    chk_alloc_take: assert property (
        expert_i.wr && expert_mode_i && nv_capable_i |=>
        alloc_save_o && (alloc_active_o == $past(expert_i.alloc_map)))
        else $error("accepted allocation not activated");
    chk_swap_take: assert property (
        expert_i.wr && expert_mode_i |=> relay_swap_o == $past(expert_i.relay_swap))
        else $error("relay swap write lost");
    chk_swap_fault: assert property (
        mode_o == SSMIO_ST_TEST && relay_swap_o |=> !relays_o.alarm_rly)
        else $error("swapped alarm relay not showing fault");
    chk_wait_dead: assert property (
        mode_o == SSMIO_ST_WAIT |=> relays_o == '0)
        else $error("relay energised in wait state");
endmodule

/* File: verilog/ssmio_cfg.svh */
// Constants for the scanner mode and relay control block
`ifndef SSMIO_CFG_SVH
`define SSMIO_CFG_SVH
`define SSMIO_NUM_IN 4
`define SSMIO_NUM_FIELDS 9
`define SSMIO_FIELD_W 4
`define SSMIO_CLK_MHZ 25
`define SSMIO_DB_TIME_US 10000
`define SSMIO_DB_CYCLES (`SSMIO_DB_TIME_US * `SSMIO_CLK_MHZ)
`define SSMIO_CNT_W 18
`define SSMIO_FN_ARM 0
`define SSMIO_FN_TEST 1
`define SSMIO_FN_NIGHT 2
`define SSMIO_FN_TEACH 3
`define SSMIO_TAMPER_IDX 4
`define SSMIO_ALLOC_W 2
`define SSMIO_ALLOC_RST 8'he4
`endif

/* File: verilog/ssmio_pkg.sv */
// Types shared by the scanner mode and relay control block
package ssmio_pkg;
    typedef enum logic [4:0] {
        SSMIO_ST_WAIT = 5'b00001,
        SSMIO_ST_ARMED = 5'b00010,
        SSMIO_ST_DISARMED = 5'b00100,
        SSMIO_ST_TEST = 5'b01000,
        SSMIO_ST_TEACH = 5'b10000
    } ssmio_mode_e;

    typedef struct packed {
        logic alarm_rly;
        logic fault_rly;
        logic sab_rly;
    } ssmio_relay_s;

    typedef struct packed {
        logic [8:0] day_en;
        logic [8:0] night_en;
        logic [3:0] teach_field;
    } ssmio_fieldcfg_s;

    typedef struct packed {
        logic wr;
        logic [7:0] alloc_map;
        logic relay_swap;
    } ssmio_expert_s;
endpackage

/* File: verilog/ssmio_debounce.sv */
// Two-stage synchroniser followed by a stable-level debouncer
`timescale 1ns/10ps
`include "ssmio_cfg.svh"
module ssmio_debounce #(
    parameter int unsigned CNT_W = `SSMIO_CNT_W,
    parameter logic [CNT_W-1:0] DB_CYCLES = CNT_W'(`SSMIO_DB_CYCLES)
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic raw_i,
    output logic level_o,
    output logic valid_o
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic cand;
        logic [CNT_W-1:0] cnt;
        logic level;
        logic valid;
    } ssmio_db_st_s;

    ssmio_db_st_s st_r;
    ssmio_db_st_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = raw_i;
        st_nxt.sync2 = st_r.sync1;
        if (st_r.sync2 != st_r.cand) begin
            st_nxt.cand = st_r.sync2;
            st_nxt.cnt = '0;
        end else if (st_r.cnt != DB_CYCLES - CNT_W'(1)) begin
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end else begin
            // Level only moves after a full quiet period
            st_nxt.level = st_r.cand;
            st_nxt.valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.level;
    assign valid_o = st_r.valid;

    chk_db_quiet: assert property (
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        st_r.cnt != DB_CYCLES - CNT_W'(1) |=> $stable(level_o))
        else $error("debounced level moved before quiet period ended");
endmodule

/* File: verif/ssmio_partner.sv */
// Switch contacts and alarm panel model at the scanner's far side
`timescale 1ns/10ps
module ssmio_partner (
    input wire logic sys_clk_i,
    input wire logic [3:0] want_sw_i,
    input wire logic want_tamper_i,
    input wire ssmio_pkg::ssmio_relay_s relays_i,
    output logic [3:0] sw_in_o,
    output logic tamper_open_o,
    output logic [7:0] alarms_o
);
    import ssmio_pkg::*;
    logic prev_r = 1'b0;
    logic [7:0] alarm_cnt_r = 8'h00;
    assign alarms_o = alarm_cnt_r;
    // Dry contacts, so the level simply follows the wanted one
    assign sw_in_o = want_sw_i;
    assign tamper_open_o = want_tamper_i;
    // Panel counts each drop of the alarm relay as one alarm
    always @(posedge sys_clk_i) begin
        prev_r <= relays_i.alarm_rly;
        if (prev_r === 1'b1 && relays_i.alarm_rly === 1'b0) begin
            alarm_cnt_r <= alarm_cnt_r + 8'h01;
        end
    end
endmodule

/* File: verif/ssmio_top_test.sv */
// Self-checking bench for the scanner mode and relay block
`timescale 1ns/10ps
module ssmio_top_test;
    import ssmio_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] want_sw = 4'h0;
    logic want_tamper = 1'b0;
    logic [3:0] sw_in;
    logic tamper_open;
    ssmio_fieldcfg_s field_cfg = '0;
    logic [8:0] case_hit = 9'h000;
    logic expert_mode = 1'b0;
    logic nv_capable = 1'b0;
    ssmio_expert_s expert = '0;
    logic sab_clr = 1'b0;
    ssmio_relay_s relays;
    ssmio_mode_e mode;
    logic night, display_on, service_on, teach_start, sabotage, sab_seen, alloc_save, relay_swap;
    logic [8:0] case_act;
    logic [3:0] teach_field;
    logic [7:0] alloc_active, alloc_pend, alarms;
    int errors = 0;
    int num_checks = 0;
    int starts = 0;

    // Short debounce count keeps the run brief
    ssmio_top #(.CNT_W(18), .DB_CYCLES(18'h4)) u_ssmio_top (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .sw_in_i(sw_in), .tamper_open_i(tamper_open),
        .field_cfg_i(field_cfg), .case_hit_i(case_hit), .expert_mode_i(expert_mode),
        .nv_capable_i(nv_capable), .expert_i(expert), .sab_clr_i(sab_clr),
        .relays_o(relays), .mode_o(mode), .night_o(night), .case_act_o(case_act),
        .display_on_o(display_on), .service_on_o(service_on), .teach_start_o(teach_start),
        .teach_field_o(teach_field), .sabotage_o(sabotage), .sab_seen_o(sab_seen),
        .alloc_active_o(alloc_active), .alloc_pend_o(alloc_pend), .alloc_save_o(alloc_save),
        .relay_swap_o(relay_swap));
    ssmio_partner u_ssmio_partner (
        .sys_clk_i(sys_clk), .want_sw_i(want_sw), .want_tamper_i(want_tamper),
        .relays_i(relays), .sw_in_o(sw_in), .tamper_open_o(tamper_open), .alarms_o(alarms));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (teach_start === 1'b1) starts++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Lets the debouncer settle, then waits for the mode, then for relays
    task automatic set_sw(input logic [3:0] v, input ssmio_mode_e exp);
        want_sw = v;
        step(12);
        for (int i = 0; i < 40 && mode !== exp; i++) step(1);
        if (mode !== exp) begin
            errors++;
            final_report();
        end else step(2);
    endtask
    task automatic ex_wr(input logic [7:0] m, input logic s);
        expert = '{1'b1, m, s};
        step(1);
        expert.wr = 1'b0;
    endtask

    task automatic t_reset();
        check({relays, mode, alloc_active}, {3'h0, SSMIO_ST_WAIT, 8'he4});
        arst_n = 1'b1;
        step(3);
        check({relays, mode}, {3'h0, SSMIO_ST_WAIT});
    endtask
    task automatic t_modes();
        ssmio_mode_e m;
        for (int v = 0; v < 16; v++) begin
            m = v[1] ? SSMIO_ST_TEST : v[3] ? SSMIO_ST_TEACH :
                v[0] ? SSMIO_ST_DISARMED : SSMIO_ST_ARMED;
            set_sw(v[3:0], m);
            check(mode, m);
            check(night, v[2]);
            check(display_on, m != SSMIO_ST_ARMED);
            check(relays.fault_rly, m inside {SSMIO_ST_ARMED, SSMIO_ST_DISARMED});
            check(relays.alarm_rly, 1'b1);
            check(service_on, m != SSMIO_ST_ARMED);
        end
    endtask
    task automatic t_cases();
        field_cfg.day_en = 9'h0a5;
        field_cfg.night_en = 9'h14a;
        set_sw(4'h0, SSMIO_ST_ARMED);
        check(case_act, 9'h0a5);
        case_hit = 9'h081;
        step(2);
        check({relays.alarm_rly, alarms}, {1'b0, 8'h01});
        case_hit = 9'h002;
        step(2);
        check(relays.alarm_rly, 1'b1);
        set_sw(4'h4, SSMIO_ST_ARMED);
        check({night, case_act, relays.alarm_rly}, {1'b1, 9'h14a, 1'b0});
        set_sw(4'h5, SSMIO_ST_DISARMED);
        check(relays.alarm_rly, 1'b1);
        // Alarm stays live in function test
        set_sw(4'h6, SSMIO_ST_TEST);
        check({relays.alarm_rly, relays.fault_rly, display_on}, 3'b001);
        case_hit = 9'h000;
    endtask
    task automatic t_teach();
        int s0;
        set_sw(4'h0, SSMIO_ST_ARMED);
        s0 = starts;
        field_cfg.teach_field = 4'h8;
        set_sw(4'h8, SSMIO_ST_TEACH);
        check(starts - s0, 32'h1);
        check(teach_field, 4'h8);
        set_sw(4'h0, SSMIO_ST_ARMED);
        field_cfg.teach_field = 4'h9;
        set_sw(4'h8, SSMIO_ST_TEACH);
        check(starts - s0, 32'h1);
    endtask
    task automatic t_tamper();
        set_sw(4'h0, SSMIO_ST_ARMED);
        want_tamper = 1'b1;
        want_sw = 4'h1;
        step(2);
        want_tamper = 1'b0;
        want_sw = 4'h0;
        step(20);
        check({sabotage, mode}, {1'b0, SSMIO_ST_ARMED});
        want_tamper = 1'b1;
        step(14);
        check({sabotage, relays.sab_rly}, 2'b10);
        want_tamper = 1'b0;
        step(14);
        check({sabotage, sab_seen, relays.sab_rly}, 3'b011);
        sab_clr = 1'b1;
        step(1);
        sab_clr = 1'b0;
        step(1);
        check(sab_seen, 1'b0);
    endtask
    task automatic t_expert();
        set_sw(4'h2, SSMIO_ST_TEST);
        ex_wr(8'h1b, 1'b1);
        check({alloc_pend, relay_swap}, {8'he4, 1'b0});
        // Let an edge pass so the strobe is seen low between writes
        step(1);
        expert_mode = 1'b1;
        ex_wr(8'h1b, 1'b1);
        check({alloc_pend, alloc_active, alloc_save, relay_swap}, {16'h1be4, 2'b01});
        step(2);
        check({relays.alarm_rly, relays.fault_rly}, 2'b01);
        nv_capable = 1'b1;
        ex_wr(8'h1b, 1'b0);
        check({alloc_active, alloc_save}, {8'h1b, 1'b1});
        step(1);
        check(alloc_save, 1'b0);
        set_sw(4'h8, SSMIO_ST_DISARMED);
        check({mode, night}, {SSMIO_ST_DISARMED, 1'b0});
        ex_wr(8'he4, 1'b0);
        expert_mode = 1'b0;
        check(alloc_active, 8'he4);
    endtask

    initial begin
        step(8);
        t_reset();
        t_modes();
        t_cases();
        t_teach();
        t_tamper();
        t_expert();
        final_report();
    end
endmodule
